// file: logic/digital_input_capture_unit.sv
// Sixteen-channel digital input capture unit with trigger, delay and interrupt pacing.
// Assumes configuration ports are static or from same-clock logic; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module digital_input_capture_unit
   import dicu_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [NUM_CH-1:0]     din_i,
   input  wire logic                  trig1_i,
   input  wire logic                  trig2_i,
   input  wire logic [1:0]            trig_mode_i,
   input  wire logic                  gate_en_i,
   input  wire logic [10:0]           tooth_width_i,
   input  wire logic [7:0]            irq_spacing_i,
   input  wire logic [3*NUM_CH-1:0]   mode_i,
   input  wire logic [NUM_CH-1:0]     act_low_i,
   input  wire logic [2*NUM_CH-1:0]   edge_sel_i,
   input  wire logic [NUM_CH-1:0]     use_hw_i,
   input  wire logic [NUM_CH-1:0]     irq_en_i,
   input  wire logic [NUM_CH-1:0]     task_i,
   input  wire logic [NUM_CH-1:0]     hyst_ttl_i,
   input  wire logic [8*NUM_CH-1:0]   low_thr_i,
   input  wire logic [8*NUM_CH-1:0]   high_thr_i,
   input  wire logic [16*NUM_CH-1:0]  timeout_i,
   input  wire logic [NUM_CH-1:0]     poll_req_i,
   input  wire logic [NUM_CH-1:0]     err_clr_i,
   input  wire logic                  adjust_en_i,
   input  wire logic                  adj_wr_i,
   input  wire logic [3:0]            adj_chan_i,
   input  wire logic [15:0]           adj_time_delay_i,
   input  wire logic [15:0]           adj_angle_delay_i,
   input  wire logic [15:0]           adj_angle_interval_i,
   input  wire logic [3:0]            rd_chan_i,
   input  wire logic                  rd_ack_i,
   output logic                       irq_o,
   output logic [NUM_CH-1:0]          irq_chan_o,
   output logic [NUM_CH-1:0]          err_o,
   output logic [8*NUM_CH-1:0]        thr_low_o,
   output logic [8*NUM_CH-1:0]        thr_high_o,
   output logic [ANG_W-1:0]           angle_pos_o,
   output logic [31:0]                timebase_o,
   output logic                       rd_fresh_o,
   output logic                       rd_state_o,
   output logic [TW-1:0]              rd_active_o,
   output logic [TW-1:0]              rd_inactive_o,
   output logic [TW-1:0]              rd_period_o,
   output logic [TW-1:0]              rd_accum_o,
   output logic [15:0]                rd_count_o
);

   // ----------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------
   logic [7:0]  us_div;
   logic [11:0] to_div;
   logic        tick_us;
   logic        tick_to;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         us_div     <= 8'h00;
         tick_us    <= 1'b0;
         timebase_o <= 32'h0000_0000;
      end else begin
         tick_us <= (us_div == US_DIV_LAST); // RQ25
         us_div  <= (us_div == US_DIV_LAST) ? 8'h00 : us_div + 8'h01;
         if (tick_us) begin
            timebase_o <= timebase_o + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         to_div  <= 12'h000;
         tick_to <= 1'b0;
      end else begin
         tick_to <= tick_us && (to_div == TO_DIV_LAST);
         if (tick_us) begin
            to_div <= (to_div == TO_DIV_LAST) ? 12'h000 : to_div + 12'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Board-wide trigger and angle counter
   // ----------------------------------------------------------------
   trig_mode_t tmode;
   logic       t1_act, t1_rise, t1_fall;
   logic       t2_act, t2_fall;
   logic [14:0]      teeth;
   logic             ang_step;
   logic [10:0]      tooth_eff;
   logic [ANG_W-1:0] next_angle_pos;

   assign tmode = trig_mode_t'(trig_mode_i); // RQ12

   input_edge_cond u_trig1 (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .pin_i         (trig1_i),
      .act_low_i     (1'b0),
      .active_o      (t1_act),
      .to_active_o   (t1_rise),
      .to_inactive_o (t1_fall)
   );

   input_edge_cond u_trig2 (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .pin_i         (trig2_i),
      .act_low_i     (1'b0),
      .active_o      (t2_act),
      .to_active_o   (),
      .to_inactive_o (t2_fall)
   );

   wire gate_ok    = ~gate_en_i | t2_act;
   wire board_trig = ((tmode == TM_RISING) || (tmode == TM_STATE)) && t1_rise && gate_ok;
   wire trig_on    = (tmode != TM_OFF);
   wire is_angle   = (tmode == TM_ANGLE);

   // Tooth width is in half degrees; out-of-range codes are pinned to the nearest legal one.
   assign tooth_eff = (tooth_width_i == 11'h000) ? 11'h001 :
                      (tooth_width_i > TOOTH_MAX) ? TOOTH_MAX : tooth_width_i; // RQ1
   assign next_angle_pos = is_angle ? ANG_W'(teeth * tooth_eff) : '0; // RQ1

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         teeth       <= 15'h0000;
         angle_pos_o <= '0;
         ang_step    <= 1'b0;
      end else begin
         if (!is_angle || t1_rise) begin
            teeth <= 15'h0000; // RQ23
         end else if (t2_fall) begin
            teeth <= teeth + 15'h0001; // RQ23
         end
         angle_pos_o <= next_angle_pos;
         ang_step    <= is_angle && (next_angle_pos != angle_pos_o);
      end
   end

   // ----------------------------------------------------------------
   // Adjustment values per channel
   // ----------------------------------------------------------------
   logic [15:0] tdelay [NUM_CH];
   logic [15:0] adelay [NUM_CH];
   logic [15:0] aint   [NUM_CH];

   wire adj_ok = adj_wr_i && adjust_en_i && trig_on; // RQ21

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            tdelay[i] <= 16'h0000;
            adelay[i] <= 16'h0000;
            aint[i]   <= 16'h0000;
         end
      end else if (adj_ok) begin
         tdelay[adj_chan_i] <= adj_time_delay_i;
         adelay[adj_chan_i] <= adj_angle_delay_i;
         aint[adj_chan_i]   <= adj_angle_interval_i;
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   logic [15:0]   dly_cnt   [NUM_CH];
   logic          dly_run   [NUM_CH];
   logic          win_open  [NUM_CH];
   logic [TW-1:0] phase     [NUM_CH];
   logic [TW-1:0] last_act  [NUM_CH];
   logic [TW-1:0] last_inact[NUM_CH];
   logic [TW-1:0] pwm_act   [NUM_CH];
   logic [TW-1:0] pwm_inact [NUM_CH];
   logic [TW-1:0] accum     [NUM_CH];
   logic [15:0]   cnt       [NUM_CH];
   logic [15:0]   to_cnt    [NUM_CH];
   logic          res_state [NUM_CH];
   logic [TW-1:0] res_act   [NUM_CH];
   logic [TW-1:0] res_inact [NUM_CH];
   logic [TW-1:0] res_accum [NUM_CH];
   logic [15:0]   res_cnt   [NUM_CH];
   logic [NUM_CH-1:0]   done_w;
   logic [NUM_CH-1:0]   irq_w;
   logic [NUM_CH-1:0]   err_set_w;
   logic [8*NUM_CH-1:0] thr_low_w;
   logic [8*NUM_CH-1:0] thr_high_w;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch // RQ4
      chan_mode_t cmode;
      edge_sel_t  esel;
      logic       act, rise, fall;
      logic [7:0] hi_user;
      logic [15:0] tmo;

      assign cmode = chan_mode_t'(mode_i[3*g +: 3]);
      assign esel  = edge_sel_t'(edge_sel_i[2*g +: 2]);
      assign tmo   = timeout_i[16*g +: 16];

      input_edge_cond u_in (
         .clk_i         (clk_i),
         .rst_i         (rst_i),
         .pin_i         (din_i[g]),
         .act_low_i     (act_low_i[g]), // RQ16
         .active_o      (act),
         .to_active_o   (rise),
         .to_inactive_o (fall)
      );

      // Codes 5 to 7 are treated like off.
      wire en     = (cmode == CM_STATE) || (cmode == CM_PWM) ||
                    (cmode == CM_ACCUM) || (cmode == CM_COUNT); // RQ5
      wire hw     = use_hw_i[g] && trig_on; // RQ10
      wire sig    = (esel == EDGE_RISE) ? rise :
                    (esel == EDGE_FALL) ? fall : (rise | fall); // RQ17 RQ18
      wire fire   = en && hw && ((board_trig && tdelay[g] == 16'h0000) ||
                    (dly_run[g] && tick_us && dly_cnt[g] == 16'h0001));
      wire [16:0] ang_end = {1'b0, adelay[g]} + {1'b0, aint[g]};
      wire a_start = en && hw && is_angle && ang_step &&
                     angle_pos_o == ANG_W'(adelay[g]);
      wire a_end   = en && hw && is_angle && ang_step &&
                     angle_pos_o == ANG_W'(ang_end) && win_open[g];
      wire poll    = en && !use_hw_i[g] && poll_req_i[g]; // RQ11
      wire st_start = poll || fire || a_start;
      wire st_end   = poll || a_end ||
                      (fire && tmode == TM_RISING) ||
                      (t1_fall && tmode == TM_STATE && win_open[g] && en && hw);
      wire xfer     = task_i[g] || (irq_en_i[g] && use_hw_i[g]); // RQ22

      assign done_w[g]    = st_end && xfer;
      assign irq_w[g]     = done_w[g] && irq_en_i[g] && hw; // RQ15
      assign err_set_w[g] = en && tmo != 16'h0000 && to_cnt[g] == tmo; // RQ24

      // The lower threshold is kept at least one step under the upper one.
      assign hi_user = (high_thr_i[8*g +: 8] == 8'h00) ? 8'h01 : high_thr_i[8*g +: 8];
      assign thr_high_w[8*g +: 8] = hyst_ttl_i[g] ? TTL_HIGH : hi_user; // RQ20
      assign thr_low_w[8*g +: 8]  = hyst_ttl_i[g] ? TTL_LOW :
                                    (low_thr_i[8*g +: 8] >= hi_user) ? hi_user - 8'h01 :
                                    low_thr_i[8*g +: 8]; // RQ19

      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            dly_cnt[g]  <= 16'h0000;
            dly_run[g]  <= 1'b0;
            win_open[g] <= 1'b0;
         end else begin
            if (!en || !hw || (tmode == TM_STATE && t1_fall)) begin
               dly_run[g] <= 1'b0;
            end else if (board_trig && tdelay[g] != 16'h0000) begin
               dly_cnt[g] <= tdelay[g];
               dly_run[g] <= 1'b1;
            end else if (dly_run[g] && tick_us) begin
               dly_cnt[g] <= dly_cnt[g] - 16'h0001;
               dly_run[g] <= (dly_cnt[g] != 16'h0001);
            end
            if (st_start) begin
               win_open[g] <= 1'b1;
            end else if (st_end || !en) begin
               win_open[g] <= 1'b0;
            end
         end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            phase[g]      <= '0;
            last_act[g]   <= '0;
            last_inact[g] <= '0;
            pwm_act[g]    <= '0;
            pwm_inact[g]  <= '0;
            accum[g]      <= '0;
            cnt[g]        <= 16'h0000;
            to_cnt[g]     <= 16'h0000;
         end else if (!en) begin
            phase[g]  <= '0;
            accum[g]  <= '0;
            cnt[g]    <= 16'h0000;
            to_cnt[g] <= 16'h0000;
         end else begin
            if (rise || fall) begin
               phase[g]  <= '0;
               to_cnt[g] <= 16'h0000;
               if (fall) last_act[g] <= phase[g];
               if (rise) last_inact[g] <= phase[g];
            end else begin
               if (tick_us && phase[g] != '1) phase[g] <= phase[g] + 1'b1;
               if (tick_to && to_cnt[g] != 16'hFFFF) to_cnt[g] <= to_cnt[g] + 16'h0001;
            end
            if (cmode == CM_PWM && sig) begin
               pwm_act[g]   <= fall ? phase[g] : last_act[g]; // RQ7
               pwm_inact[g] <= rise ? phase[g] : last_inact[g]; // RQ7
            end
            if (st_start) begin
               accum[g] <= '0;
               cnt[g]   <= 16'h0000;
            end else begin
               if (cmode == CM_ACCUM && act && tick_us && accum[g] != '1) begin
                  accum[g] <= accum[g] + 1'b1; // RQ8
               end
               if (cmode == CM_COUNT && sig && cnt[g] != 16'hFFFF) begin
                  cnt[g] <= cnt[g] + 16'h0001; // RQ9
               end
            end
         end
      end

      // Results are the buffer that a polling host reads; off channels never update it.
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            res_state[g] <= 1'b0;
            res_act[g]   <= '0;
            res_inact[g] <= '0;
            res_accum[g] <= '0;
            res_cnt[g]   <= 16'h0000;
         end else if (done_w[g]) begin
            res_state[g] <= act; // RQ6
            res_act[g]   <= pwm_act[g]; // RQ7
            res_inact[g] <= pwm_inact[g]; // RQ7
            res_accum[g] <= accum[g]; // RQ8
            res_cnt[g]   <= cnt[g]; // RQ9
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt pacing, flags and readout
   // ----------------------------------------------------------------
   logic [NUM_CH-1:0] pend;
   logic [NUM_CH-1:0] fresh;
   logic [14:0]       sp_cnt;

   wire [14:0] sp_limit = 15'(irq_spacing_i * SPACING_STEP_US); // RQ2
   wire sp_ok  = !trig_on || (sp_cnt >= sp_limit); // RQ3
   wire irq_go = (pend != '0) && sp_ok;
   wire [NUM_CH-1:0] rd_clr = rd_ack_i ? (NUM_CH'(1) << rd_chan_i) : '0;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend       <= '0;
         sp_cnt     <= 15'h0000;
         irq_o      <= 1'b0;
         irq_chan_o <= '0;
      end else begin
         irq_o <= irq_go; // RQ13
         if (irq_go) begin
            irq_chan_o <= pend;
            pend       <= irq_w; // RQ13
            sp_cnt     <= 15'h0000; // RQ2
         end else begin
            pend <= pend | irq_w; // RQ13
            if (tick_us && sp_cnt != 15'h7FFF) sp_cnt <= sp_cnt + 15'h0001;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fresh      <= '0;
         err_o      <= '0;
         thr_low_o  <= '0;
         thr_high_o <= '0;
      end else begin
         fresh      <= (fresh & ~rd_clr) | done_w; // RQ14
         err_o      <= (err_o & ~err_clr_i) | err_set_w; // RQ24
         thr_low_o  <= thr_low_w;
         thr_high_o <= thr_high_w;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_fresh_o    <= 1'b0;
         rd_state_o    <= 1'b0;
         rd_active_o   <= '0;
         rd_inactive_o <= '0;
         rd_period_o   <= '0;
         rd_accum_o    <= '0;
         rd_count_o    <= 16'h0000;
      end else begin
         rd_fresh_o    <= fresh[rd_chan_i]; // RQ14
         rd_state_o    <= res_state[rd_chan_i];
         rd_active_o   <= res_act[rd_chan_i];
         rd_inactive_o <= res_inact[rd_chan_i];
         rd_period_o   <= res_act[rd_chan_i] + res_inact[rd_chan_i]; // RQ7
         rd_accum_o    <= res_accum[rd_chan_i];
         rd_count_o    <= res_cnt[rd_chan_i];
      end
   end

endmodule // digital_input_capture_unit

`default_nettype wire

// file: pkg/dicu_pkg.sv
// Constants and types shared by the digital input capture unit.
// Assumes one 250 MHz clock and an asynchronous, active-high reset.
//
// Behaviour
// [RQ1] Tooth width 0.5 to 720 deg, angle mode only.
// [RQ2] Programmable interrupt spacing, 0.1 ms steps, 25.5 ms max.
// [RQ3] Spacing ignored while board trigger is off.
// [RQ4] Sixteen independent input channels.
// [RQ5] Off channel evaluates nothing, reports nothing.
// [RQ6] State sampling reports level at request.
// [RQ7] PWM reports last completed period before request.
// [RQ8] Accumulated mode sums active time in interval.
// [RQ9] Edge mode counts significant edges in interval.
// [RQ10] Hardware trigger synchronises channel acquisition.
// [RQ11] Without hardware trigger, host polls each acquisition.
// [RQ12] One board-wide trigger mode for all channels.
// [RQ13] Interrupt raised when acquisition completes.
// [RQ14] Without interrupt, results wait in buffer for polling.
// [RQ15] Interrupt needs hardware trigger enabled too.
// [RQ16] Per-channel polarity defines active level.
// [RQ17] Significant edge: rising, falling or both.
// [RQ18] Edge selection only for counting and PWM.
// [RQ19] Lower threshold 0.144 V steps, below upper.
// [RQ20] TTL hysteresis forces 1.728 V and 2.304 V.
// [RQ21] Runtime delay adjustment only while triggered.
// [RQ22] Transfer enabled by task or interrupt only.
// [RQ23] Trigger 1 rise clears, trigger 2 fall increments angle.
// [RQ24] Timeout error in 2.5 ms steps, zero disables.
// [RQ25] All timing from one free-running timebase.

package dicu_pkg;

   localparam int NUM_CH          = 16;
   localparam int TW              = 24;
   localparam int ANG_W           = 26;

   localparam int CLK_PERIOD_PS   = 4000;
   localparam int US_PS           = 1000000;
   localparam int US_CYCLES       = US_PS / CLK_PERIOD_PS;
   localparam logic [7:0] US_DIV_LAST = 8'(US_CYCLES - 1);

   localparam int SPACING_STEP_US = 100;
   localparam int TIMEOUT_STEP_US = 2500;
   localparam logic [11:0] TO_DIV_LAST = 12'(TIMEOUT_STEP_US - 1);

   localparam logic [10:0] TOOTH_MAX   = 11'h5A0;
   localparam logic [7:0]  TTL_LOW     = 8'h0C;
   localparam logic [7:0]  TTL_HIGH    = 8'h10;

   typedef enum logic [2:0] {CM_OFF, CM_STATE, CM_PWM, CM_ACCUM, CM_COUNT} chan_mode_t;
   typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;
   typedef enum logic [1:0] {TM_OFF, TM_RISING, TM_STATE, TM_ANGLE} trig_mode_t;

endpackage

// file: logic/input_edge_cond.sv
// Two-stage synchroniser, polarity and edge detection for one input pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module input_edge_cond (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   input  wire logic act_low_i,
   output logic      active_o,
   output logic      to_active_o,
   output logic      to_inactive_o
);

   logic meta;
   logic sync;
   logic level;
   wire  next_level = sync ^ act_low_i;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta  <= 1'b0;
         sync  <= 1'b0;
         level <= 1'b0;
      end else begin
         meta  <= pin_i;
         sync  <= meta;
         level <= next_level;
      end
   end

   // A polarity change at runtime shows as one edge; hosts change it while the channel is off.
   assign active_o      = level;
   assign to_active_o   = next_level & ~level;
   assign to_inactive_o = ~next_level & level;

endmodule // input_edge_cond

`default_nettype wire

// file: tb/dicu_host.sv
// Host model: collects interrupt requests raised by the capture unit.
// Assumes it shares the unit's clock and sees irq_o and irq_chan_o directly.
`timescale 1ns/100ps
`default_nettype none

module dicu_host (
   input  wire logic        clk_i,
   input  wire logic        irq_i,
   input  wire logic [15:0] irq_chan_i,
   output var  int          irq_seen_o,
   output var  logic [15:0] last_chan_o
);
   initial begin
      irq_seen_o  = 0;
      last_chan_o = 16'h0000;
   end

   // The host reads the served channels in the same cycle as the pulse,
   // because the unit only guarantees the pulse for one cycle.
   always @(posedge clk_i) begin
      if (irq_i === 1'b1) begin
         irq_seen_o  <= irq_seen_o + 1;
         last_chan_o <= irq_chan_i;
      end
   end
endmodule // dicu_host

`default_nettype wire

// file: tb/dicu_chk.sv
// Port checker for the capture unit, bound to every instance of it.
// Assumes configuration inputs stay still while a property is in play.
`timescale 1ns/100ps
`default_nettype none

module dicu_chk
   import dicu_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [1:0]    trig_mode_i,
   input  wire logic [7:0]    irq_spacing_i,
   input  wire logic [47:0]   mode_i,
   input  wire logic [15:0]   use_hw_i,
   input  wire logic [15:0]   irq_en_i,
   input  wire logic [15:0]   task_i,
   input  wire logic [15:0]   hyst_ttl_i,
   input  wire logic [255:0]  timeout_i,
   input  wire logic [15:0]   poll_req_i,
   input  wire logic [3:0]    rd_chan_i,
   input  wire logic          rd_ack_i,
   input  wire logic          irq_o,
   input  wire logic [15:0]   irq_chan_o,
   input  wire logic [15:0]   err_o,
   input  wire logic [127:0]  thr_low_o,
   input  wire logic [127:0]  thr_high_o,
   input  wire logic [25:0]   angle_pos_o,
   input  wire logic [31:0]   timebase_o,
   input  wire logic          rd_fresh_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Cycles since the previous pulse; the spacing is counted in whole
   // microsecond ticks, so one tick of slack is allowed below.
   logic [31:0] gap;
   logic        seen;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap  <= 32'h0;
         seen <= 1'b0;
      end else begin
         gap  <= irq_o ? 32'h0 : gap + 32'h1;
         seen <= seen | irq_o;
      end
   end

   property p_ttl;
      hyst_ttl_i[0] [*3] |-> thr_low_o[7:0] == 8'h0C && thr_high_o[7:0] == 8'h10;
   endproperty
   a_ttl: assert property (p_ttl) else $error("fixed thresholds not applied");
   property p_order;
      thr_high_o[7:0] != 8'h00 |-> thr_low_o[7:0] < thr_high_o[7:0];
   endproperty
   a_order: assert property (p_order) else $error("lower threshold not below upper");
   property p_angle;
      (trig_mode_i != 2'h3) [*3] |-> angle_pos_o == 26'h0;
   endproperty
   a_angle: assert property (p_angle) else $error("angle nonzero outside angle mode");
   property p_space;
      irq_o && seen && trig_mode_i != 2'h0 |-> gap + 32'd250 >= 32'(irq_spacing_i) * 32'd25000;
   endproperty
   a_space: assert property (p_space) else $error("interrupts too close");
   property p_chan;
      irq_o |-> (irq_chan_o & ~(use_hw_i & irq_en_i)) == 16'h0000;
   endproperty
   a_chan: assert property (p_chan) else $error("interrupt for untriggered channel");
   property p_tb;
      $changed(timebase_o) |-> timebase_o == $past(timebase_o) + 32'h1 ##1 $stable(timebase_o) [*8];
   endproperty
   a_tb: assert property (p_tb) else $error("timebase step wrong");
   property p_tick;
      $changed(timebase_o) |-> ##[1:250] $changed(timebase_o);
   endproperty
   a_tick: assert property (p_tick) else $error("timebase stalled");
   property p_noto;
      (timeout_i[15:0] == 16'h0000) [*2] |-> !$rose(err_o[0]);
   endproperty
   a_noto: assert property (p_noto) else $error("timeout error while disabled");
   property p_off;
      (mode_i[2:0] == 3'h0 && rd_chan_i == 4'h0) [*3] ##0 !rd_fresh_o |=> !rd_fresh_o;
   endproperty
   a_off: assert property (p_off) else $error("result from channel that is off");
   property p_poll;
      poll_req_i[0] && !use_hw_i[0] && task_i[0] && mode_i[2:0] == 3'h1 && rd_chan_i == 4'h0
         && !rd_ack_i |-> ##[1:3] rd_fresh_o;
   endproperty
   a_poll: assert property (p_poll) else $error("polled result not fresh");
endmodule // dicu_chk

bind digital_input_capture_unit dicu_chk u_chk (.clk_i, .rst_i, .trig_mode_i, .irq_spacing_i,
   .mode_i, .use_hw_i, .irq_en_i, .task_i, .hyst_ttl_i, .timeout_i, .poll_req_i, .rd_chan_i,
   .rd_ack_i, .irq_o, .irq_chan_o, .err_o, .thr_low_o, .thr_high_o, .angle_pos_o, .timebase_o,
   .rd_fresh_o);

`default_nettype wire

// file: tb/digital_input_capture_unit_tb.sv
// Self-checking bench for the capture unit with a host model on its interrupt side.
// Assumes a 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none

module digital_input_capture_unit_tb;
   import dicu_pkg::*;
   logic clk_i, rst_i, trig1, trig2, gate, adj_en, adj_wr, rd_ack, irq, fresh, state;
   logic [1:0] tmode;
   logic [3:0] adj_ch, rd_ch;
   logic [7:0] space;
   logic [10:0] tooth;
   logic [15:0] din, act_low, use_hw, irq_en, tsk, hyst, poll, eclr, adj_td, adj_ad, adj_ai;
   logic [15:0] irq_ch, r_cnt, host_chan;
   logic [25:0] ang;
   logic [31:0] edge_s;
   logic [47:0] mode;
   logic [127:0] lo, hi, thr_lo, thr_hi;
   logic [255:0] tmo;
   int err_count, num_checks, host_n;

   digital_input_capture_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .din_i(din), .trig1_i(trig1),
      .trig2_i(trig2), .trig_mode_i(tmode), .gate_en_i(gate), .tooth_width_i(tooth),
      .irq_spacing_i(space), .mode_i(mode), .act_low_i(act_low), .edge_sel_i(edge_s),
      .use_hw_i(use_hw), .irq_en_i(irq_en), .task_i(tsk), .hyst_ttl_i(hyst), .low_thr_i(lo),
      .high_thr_i(hi), .timeout_i(tmo), .poll_req_i(poll), .err_clr_i(eclr),
      .adjust_en_i(adj_en), .adj_wr_i(adj_wr), .adj_chan_i(adj_ch), .adj_time_delay_i(adj_td),
      .adj_angle_delay_i(adj_ad), .adj_angle_interval_i(adj_ai), .rd_chan_i(rd_ch),
      .rd_ack_i(rd_ack), .irq_o(irq), .irq_chan_o(irq_ch), .err_o(), .thr_low_o(thr_lo),
      .thr_high_o(thr_hi), .angle_pos_o(ang), .timebase_o(), .rd_fresh_o(fresh),
      .rd_state_o(state), .rd_active_o(), .rd_inactive_o(), .rd_period_o(), .rd_accum_o(),
      .rd_count_o(r_cnt));

   dicu_host u_host (.clk_i(clk_i), .irq_i(irq), .irq_chan_i(irq_ch), .irq_seen_o(host_n),
      .last_chan_o(host_chan));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic poll0;
      poll[0] = 1'b1;
      cyc(1);
      poll[0] = 1'b0;
      cyc(4);
   endtask
   task automatic ack0;
      rd_ack = 1'b1;
      cyc(1);
      rd_ack = 1'b0;
      cyc(2);
   endtask
   task automatic pulse(input int bit_no);
      din[bit_no] = 1'b1;
      cyc(6);
      din[bit_no] = 1'b0;
      cyc(6);
   endtask
   task automatic trg;
      trig1 = 1'b1;
      cyc(10);
      trig1 = 1'b0;
      cyc(10);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_thresh;
      hyst[0] = 1'b1;
      lo[15:8] = 8'h05;
      hi[15:8] = 8'h09;
      lo[23:16] = 8'h09;
      hi[23:16] = 8'h09;
      cyc(4);
      chk(thr_lo[7:0], 8'h0C);
      chk(thr_hi[7:0], 8'h10);
      chk(thr_lo[15:8], 8'h05);
      chk(thr_lo[23:16], 8'h08);
   endtask
   task automatic t_poll;
      mode[2:0] = 3'h1;
      tsk[0] = 1'b1;
      din[0] = 1'b1;
      cyc(5);
      poll0;
      chk(fresh, 1'b1);
      chk(state, 1'b1);
      ack0;
      chk(fresh, 1'b0);
      act_low[0] = 1'b1;
      cyc(5);
      poll0;
      chk(state, 1'b0);
      ack0;
      tsk[0] = 1'b0;
      poll0;
      chk(fresh, 1'b0);
      tsk[0] = 1'b1;
      mode[2:0] = 3'h0;
      cyc(3);
      poll0;
      chk(fresh, 1'b0);
   endtask
   task automatic t_count;
      mode[2:0] = 3'h4;
      act_low[0] = 1'b0;
      din[0] = 1'b0;
      cyc(5);
      for (int e = 0; e < 3; e++) begin
         edge_s[1:0] = 2'(e);
         poll0;
         repeat (3) pulse(0);
         poll0;
         chk(r_cnt, (e == 2) ? 16'h0006 : 16'h0003);
      end
   endtask
   task automatic t_irq;
      mode[5:0] = 6'o11;
      tmode = 2'h1;
      use_hw[0] = 1'b1;
      irq_en[1:0] = 2'b11;
      cyc(3);
      trg;
      for (int i = 0; i < 100 && host_n == 0; i++) cyc(1);
      chk(host_n, 1);
      chk(host_chan, 16'h0001);
      space = 8'h01;
      trg;
      cyc(20000);
      chk(host_n, 1);
      cyc(6000);
      chk(host_n, 2);
   endtask
   task automatic t_angle;
      tmode = 2'h3;
      for (int k = 0; k < 2; k++) begin
         tooth = k ? 11'h5A0 : 11'h00C;
         trg;
         repeat (3) begin
            trig2 = 1'b1;
            cyc(6);
            trig2 = 1'b0;
            cyc(6);
         end
         cyc(4);
         chk(ang, 26'(3 * tooth));
      end
      tmode = 2'h0;
      cyc(5);
      chk(ang, 26'h0);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #300000;
      err_count++;
      summarize;
   end
   initial begin
      err_count = 0;
      num_checks = 0;
      rst_i = 1'b1;
      {din, trig1, trig2, tmode, gate, tooth, space, mode, act_low, edge_s} = '0;
      {use_hw, irq_en, tsk, hyst, lo, hi, tmo, poll, eclr} = '0;
      {adj_en, adj_wr, adj_ch, adj_td, adj_ad, adj_ai, rd_ch, rd_ack} = '0;
      cyc(10);
      rst_i = 1'b0;
      cyc(2);
      t_thresh;
      t_poll;
      t_count;
      t_irq;
      t_angle;
      summarize;
   end
endmodule // digital_input_capture_unit_tb

`default_nettype wire
